//--- gsf_pkg.sv
package gsf_pkg;
  // Buffer geometry.
  localparam int CH_W = 16; // Bits per rate sample.
  localparam int NUM_CH = 3; // Yaw, pitch and roll.
  localparam int SET_W = CH_W * NUM_CH; // One stored sample set.
  localparam int DEPTH = 32; // Sample sets held by the buffer.
  localparam int BYTE_W = 8; // Register width.
  localparam int ADDR_W = 7; // Register index width.
  // Register indices.
  localparam logic [6:0] ADDR_IRQ_CFG = 7'h22; // interrupt_pin_config.
  localparam logic [6:0] ADDR_AX1_LO = 7'h28; // axis1_out_low.
  localparam logic [6:0] ADDR_AX1_HI = 7'h29; // axis1_out_high.
  localparam logic [6:0] ADDR_AX2_LO = 7'h2A; // axis2_out_low.
  localparam logic [6:0] ADDR_AX2_HI = 7'h2B; // axis2_out_high.
  localparam logic [6:0] ADDR_AX3_LO = 7'h2C; // axis3_out_low.
  localparam logic [6:0] ADDR_AX3_HI = 7'h2D; // axis3_out_high.
  localparam logic [6:0] ADDR_BUF_CTRL = 7'h2E; // buffer_control.
  localparam logic [6:0] ADDR_BUF_STAT = 7'h2F; // buffer_status.
  localparam logic [6:0] ADDR_TRIG_CFG = 7'h30; // trigger_event_config.
  // buffer_control fields.
  localparam int MODE_LSB = 5; // Mode field low bit.
  localparam int MODE_W = 3; // Mode field width.
  localparam int WTM_W = 5; // watermark_level width.
  localparam logic [2:0] MODE_BYPASS = 3'h0; // Latest sample only.
  localparam logic [2:0] MODE_FIFO = 3'h1; // Fill, then stop.
  localparam logic [2:0] MODE_STREAM = 3'h2; // Fill, then drop oldest.
  localparam logic [2:0] MODE_STREAM_TO_FIFO = 3'h3; // Stream until trigger.
  localparam logic [2:0] MODE_BYPASS_TO_STREAM = 3'h4; // Bypass until trigger.
  // buffer_status fields.
  localparam int STAT_WTM_BIT = 7; // Watermark reached.
  localparam int STAT_FULL_BIT = 6; // All entries unread.
  localparam int STAT_EMPTY_BIT = 5; // Nothing unread.
  localparam int STAT_CNT_W = 5; // Low bits of the stored count.
  // interrupt_pin_config enables.
  localparam int IRQ_WTM_BIT = 2; // watermark_irq_enable.
  localparam int IRQ_FULL_BIT = 1; // Full event enable.
  localparam int IRQ_EMPTY_BIT = 0; // Empty event enable.
  localparam logic [7:0] REG_RST = 8'h00; // Reset of writable registers.
  // Behaviour the buffer actually follows once triggers are resolved.
  typedef enum logic [1:0] {BEH_BYPASS, BEH_FIFO, BEH_STREAM} gsf_beh_t;
endpackage

//--- gsf_sync3.sv
`timescale 1ns/10ps
module gsf_sync3 (
  input wire logic clk_in, // Block clock.
  input wire logic resetn_in, // Synchronous reset, active low.
  input wire logic async_in, // Level from another domain.
  output logic rise_out // One-cycle pulse per accepted rise.
);
  logic s1_ff; // First stage, read only by the second.
  logic s2_ff; // Second stage.
  logic s3_ff; // Third stage.
  logic level_ff; // Accepted level.
  logic rise_ff; // Registered rise pulse.
  wire logic agree; // Second and third stages match.

  assign agree = (s2_ff == s3_ff);
  assign rise_out = rise_ff;

  // A change only counts once two settled stages agree, which filters a late flop.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s1_ff <= 1'h0;
      s2_ff <= 1'h0;
      s3_ff <= 1'h0;
      level_ff <= 1'h0;
      rise_ff <= 1'h0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= agree ? s3_ff : level_ff;
      rise_ff <= agree && s3_ff && !level_ff;
    end
  end
endmodule

//--- gsf_fifo.sv
`timescale 1ns/10ps
module gsf_fifo #(
  parameter int WIDTH = 16, // Word width.
  parameter int DEPTH = 16, // Words held, a power of two.
  parameter int CNT_W = $clog2(DEPTH + 1) // Count width.
) (
  input wire logic clk_in, // Block clock.
  input wire logic resetn_in, // Synchronous reset, active low.
  input wire logic flush_in, // Drop everything, pointers to zero.
  input wire logic in_valid_in, // Word offered.
  input wire logic [WIDTH-1:0] in_data_in, // Word to store.
  output logic in_ready_out, // Word can be taken.
  output logic out_valid_out, // Oldest word present.
  output logic [WIDTH-1:0] out_data_out, // Oldest word.
  input wire logic out_ready_in, // Oldest word consumed.
  output logic [CNT_W-1:0] count_out // Words stored.
);
  localparam int PTR_W = $clog2(DEPTH); // Pointer width.
  logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage, flops.
  logic [PTR_W-1:0] wr_ptr_ff; // Next slot to write.
  logic [PTR_W-1:0] rd_ptr_ff; // Oldest slot.
  logic [CNT_W-1:0] count_ff; // Words stored.
  wire logic full; // No free slot.
  wire logic push; // Word taken this cycle.
  wire logic pop; // Word consumed this cycle.
  wire logic [CNT_W-1:0] nxt_count; // Count after this cycle.

  assign full = (count_ff == CNT_W'(DEPTH));
  // A pop in the same cycle frees a slot, so a full buffer may still take a word.
  assign in_ready_out = !full || out_ready_in;
  assign out_valid_out = (count_ff != '0);
  assign out_data_out = mem_ff[rd_ptr_ff];
  assign count_out = count_ff;
  assign push = in_valid_in && in_ready_out && !flush_in;
  assign pop = out_valid_out && out_ready_in && !flush_in;
  assign nxt_count = count_ff + CNT_W'(push) - CNT_W'(pop);

  // Data slots carry no reset; only pointers and count define the state.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  // Pointers wrap naturally at a power-of-two depth.
  always_ff @(posedge clk_in) begin
    if (!resetn_in || flush_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= push ? wr_ptr_ff + PTR_W'(1) : wr_ptr_ff;
      rd_ptr_ff <= pop ? rd_ptr_ff + PTR_W'(1) : rd_ptr_ff;
      count_ff <= nxt_count;
    end
  end
endmodule

//--- gsf_gyro_sample_fifo.sv
`timescale 1ns/10ps
// Contract
// [R01] Per channel buffer, 32 entries, 16 bits.
// [R02] Five modes, chosen in buffer_control.
// [R03] Watermark, empty, full each enable the pin.
// [R04] buffer_status reports watermark, empty, full.
// [R05] Five-bit watermark level in buffer_control.
// [R06] Watermark event when count reaches level.
// [R07] Bypass keeps only latest sample, buffer empty.
// [R08] Fifo mode stops accepting when full.
// [R09] Host restarts filled fifo via bypass.
// [R10] Stream mode drops oldest when full.
// [R11] Bypass-to-stream switches to stream on trigger.
// [R12] Stream-to-fifo switches to fifo on trigger.
// [R13] Buffered modes: output registers read buffer.
// [R14] Each read set returns oldest sample set.
// [R15] Burst address wraps from 2Dh to 28h.
// [R16] Empty when none unread; full at 32.
// [R17] Bypass discards entries and resets pointers.
module gsf_gyro_sample_fifo #(
  parameter int DEPTH = gsf_pkg::DEPTH // Sample sets held.
) (
  input wire logic clk_in, // Block clock, 125 MHz.
  input wire logic resetn_in, // Synchronous reset, active low.
  input wire logic sample_clk_in, // New-sample strobe, other domain.
  input wire logic [15:0] axis1_sample_in, // Yaw sample.
  input wire logic [15:0] axis2_sample_in, // Pitch sample.
  input wire logic [15:0] axis3_sample_in, // Roll sample.
  input wire logic trigger_event_in, // Event from interrupt generator.
  input wire logic [6:0] reg_addr_in, // Register index.
  input wire logic reg_inc_in, // Use the auto-increment pointer.
  input wire logic reg_wr_in, // Write strobe.
  input wire logic [7:0] reg_wdata_in, // Write data.
  input wire logic reg_rd_in, // Read strobe.
  output logic [7:0] reg_rdata_out, // Read data.
  output logic reg_rvalid_out, // Read data valid pulse.
  output logic [7:0] trigger_event_config_out, // Config to generator.
  output logic sample_ready_out, // Buffer can take a sample.
  output logic data_ready_irq_pin_out // Interrupt pin level.
);
  localparam int CNT_W = $clog2(DEPTH + 1); // Count width.
  localparam int SET_W = gsf_pkg::SET_W; // Sample set width.
  localparam int BW = gsf_pkg::BYTE_W; // Byte width.
  localparam int AW = gsf_pkg::ADDR_W; // Index width.

  // Register state.
  logic [BW-1:0] irq_cfg_ff; // interrupt_pin_config.
  logic [BW-1:0] ctrl_ff; // buffer_control.
  logic [BW-1:0] trig_cfg_ff; // trigger_event_config.
  logic triggered_ff; // Trigger seen in a trigger mode.
  logic [AW-1:0] addr_ptr_ff; // Auto-increment pointer.
  logic [SET_W-1:0] latest_ff; // Bypass slot: latest sample set.
  logic [BW-1:0] rdata_ff; // Registered read data.
  logic rvalid_ff; // Registered read valid.
  logic irq_ff; // Registered pin level.

  // Decoded control.
  wire logic [2:0] mode_code; // Mode field.
  wire logic [gsf_pkg::WTM_W-1:0] wtm_level; // watermark_level.
  gsf_pkg::gsf_beh_t beh; // Effective behaviour.
  wire logic trig_mode; // A trigger mode is selected.
  wire logic buffered; // Reads come from the buffer.
  wire logic flush; // Buffer held empty.

  // Sample path.
  wire logic sample_new; // A fresh sample set arrived.
  wire logic [SET_W-1:0] sample_set; // Incoming set.
  wire logic fifo_in_ready; // Buffer takes a set.
  wire logic fifo_out_valid; // Oldest set present.
  wire logic [SET_W-1:0] fifo_head; // Oldest set.
  wire logic fifo_pop; // Consume oldest set.
  wire logic [CNT_W-1:0] fifo_count; // Stored sets.
  wire logic empty; // Nothing unread.
  wire logic full; // All entries unread.
  wire logic wtm_hit; // Watermark reached.
  wire logic read_pop; // Host finished a set.
  wire logic stream_drop; // Oldest dropped for room.

  // Register access.
  wire logic [AW-1:0] eff_addr; // Address of this access.
  wire logic [AW-1:0] nxt_addr_ptr; // Address of the next burst byte.
  wire logic [SET_W-1:0] out_set; // Set shown by output registers.
  wire logic [BW-1:0] status_byte; // buffer_status contents.
  wire logic [BW-1:0] rd_byte; // Selected read byte.
  wire logic nxt_triggered; // Next trigger state.
  wire logic nxt_irq; // Next pin level.

  assign mode_code = ctrl_ff[gsf_pkg::MODE_LSB +: gsf_pkg::MODE_W]; // R02
  assign wtm_level = ctrl_ff[gsf_pkg::WTM_W-1:0]; // R05

  // Trigger modes resolve to plain behaviour; unused codes act as bypass.
  always_comb begin
    unique case (mode_code)
      gsf_pkg::MODE_FIFO: begin
        beh = gsf_pkg::BEH_FIFO; // R02
      end
      gsf_pkg::MODE_STREAM: begin
        beh = gsf_pkg::BEH_STREAM; // R02
      end
      gsf_pkg::MODE_BYPASS_TO_STREAM: begin
        beh = triggered_ff ? gsf_pkg::BEH_STREAM : gsf_pkg::BEH_BYPASS; // R11
      end
      gsf_pkg::MODE_STREAM_TO_FIFO: begin
        beh = triggered_ff ? gsf_pkg::BEH_FIFO : gsf_pkg::BEH_STREAM; // R12
      end
      default: begin
        beh = gsf_pkg::BEH_BYPASS; // R07
      end
    endcase
  end

  assign trig_mode = (mode_code == gsf_pkg::MODE_BYPASS_TO_STREAM) ||
                     (mode_code == gsf_pkg::MODE_STREAM_TO_FIFO);
  assign buffered = (beh != gsf_pkg::BEH_BYPASS); // R13
  // Bypass empties the buffer; this is also how a filled buffer restarts.
  assign flush = (beh == gsf_pkg::BEH_BYPASS); // R17 R09

  // The trigger sets the flag; a write to buffer_control clears it, set wins.
  assign nxt_triggered = (trig_mode && trigger_event_in) ? 1'h1 :
                         (reg_wr_in && eff_addr == gsf_pkg::ADDR_BUF_CTRL) ? 1'h0 :
                         triggered_ff;

  // The sample strobe comes from the measurement domain; sample words must be
  // stable for several block cycles around its rise, since they are not resynced.
  gsf_sync3 u_sample_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(sample_clk_in),
    .rise_out(sample_new)
  );

  assign sample_set = {axis3_sample_in, axis2_sample_in, axis1_sample_in};

  // One word holds all three channels so the sets never drift apart.
  gsf_fifo #(
    .WIDTH(SET_W),
    .DEPTH(DEPTH),
    .CNT_W(CNT_W)
  ) u_buffer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .flush_in(flush),
    .in_valid_in(sample_new),
    .in_data_in(sample_set),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_head),
    .out_ready_in(fifo_pop),
    .count_out(fifo_count)
  ); // R01

  assign empty = !fifo_out_valid; // R16
  assign full = (fifo_count == CNT_W'(DEPTH)); // R16
  assign wtm_hit = (fifo_count >= CNT_W'(wtm_level)); // R06
  // In fifo behaviour a full buffer refuses samples until a set is read or bypass is written.
  // Stream always takes a sample, since the oldest set makes way for it.
  assign sample_ready_out = !flush && (fifo_in_ready || (beh == gsf_pkg::BEH_STREAM)); // R08 R10
  // Stream makes room by dropping the oldest set as the new one lands.
  assign stream_drop = (beh == gsf_pkg::BEH_STREAM) && full && sample_new; // R10
  // The last byte of a set releases it and brings the next oldest forward.
  assign read_pop = reg_rd_in && buffered && !empty &&
                    (eff_addr == gsf_pkg::ADDR_AX3_HI); // R14
  assign fifo_pop = read_pop || stream_drop;

  // Address of this access and of the byte after it.
  assign eff_addr = reg_inc_in ? addr_ptr_ff : reg_addr_in;
  assign nxt_addr_ptr = (eff_addr == gsf_pkg::ADDR_AX3_HI) ? gsf_pkg::ADDR_AX1_LO :
                        eff_addr + AW'(1); // R15

  // Buffered modes read the oldest set; bypass, or an empty buffer, the latest.
  assign out_set = (buffered && !empty) ? fifo_head : latest_ff; // R13

  assign status_byte[gsf_pkg::STAT_WTM_BIT] = wtm_hit; // R04
  assign status_byte[gsf_pkg::STAT_FULL_BIT] = full; // R04
  assign status_byte[gsf_pkg::STAT_EMPTY_BIT] = empty; // R04
  assign status_byte[gsf_pkg::STAT_CNT_W-1:0] = gsf_pkg::STAT_CNT_W'(fifo_count);

  // Read selection; unmapped indices read as zero.
  assign rd_byte =
    (eff_addr == gsf_pkg::ADDR_IRQ_CFG) ? irq_cfg_ff :
    (eff_addr == gsf_pkg::ADDR_AX1_LO) ? out_set[0*BW +: BW] :
    (eff_addr == gsf_pkg::ADDR_AX1_HI) ? out_set[1*BW +: BW] :
    (eff_addr == gsf_pkg::ADDR_AX2_LO) ? out_set[2*BW +: BW] :
    (eff_addr == gsf_pkg::ADDR_AX2_HI) ? out_set[3*BW +: BW] :
    (eff_addr == gsf_pkg::ADDR_AX3_LO) ? out_set[4*BW +: BW] :
    (eff_addr == gsf_pkg::ADDR_AX3_HI) ? out_set[5*BW +: BW] :
    (eff_addr == gsf_pkg::ADDR_BUF_CTRL) ? ctrl_ff :
    (eff_addr == gsf_pkg::ADDR_BUF_STAT) ? status_byte :
    (eff_addr == gsf_pkg::ADDR_TRIG_CFG) ? trig_cfg_ff :
    gsf_pkg::REG_RST;

  // Each condition reaches the pin only through its own enable.
  assign nxt_irq = (irq_cfg_ff[gsf_pkg::IRQ_WTM_BIT] && wtm_hit) ||
                   (irq_cfg_ff[gsf_pkg::IRQ_FULL_BIT] && full) ||
                   (irq_cfg_ff[gsf_pkg::IRQ_EMPTY_BIT] && empty); // R03 R06

  assign reg_rdata_out = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;
  assign trigger_event_config_out = trig_cfg_ff;
  assign data_ready_irq_pin_out = irq_ff;

  // Writable registers; the output and status indices ignore writes.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_cfg_ff <= gsf_pkg::REG_RST;
      ctrl_ff <= gsf_pkg::REG_RST;
      trig_cfg_ff <= gsf_pkg::REG_RST;
    end else if (reg_wr_in) begin
      irq_cfg_ff <= (eff_addr == gsf_pkg::ADDR_IRQ_CFG) ? reg_wdata_in : irq_cfg_ff; // R03
      ctrl_ff <= (eff_addr == gsf_pkg::ADDR_BUF_CTRL) ? reg_wdata_in : ctrl_ff; // R02 R05
      trig_cfg_ff <= (eff_addr == gsf_pkg::ADDR_TRIG_CFG) ? reg_wdata_in : trig_cfg_ff;
    end
  end

  // Burst pointer follows every access, wrapping across the output block.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      addr_ptr_ff <= gsf_pkg::ADDR_AX1_LO;
    end else if (reg_rd_in || reg_wr_in) begin
      addr_ptr_ff <= nxt_addr_ptr; // R15
    end
  end

  // The bypass slot always tracks the newest set, whatever the mode.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      latest_ff <= '0;
    end else if (sample_new) begin
      latest_ff <= sample_set; // R07
    end
  end

  // Trigger flag, read data and pin level.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      triggered_ff <= 1'h0;
      rdata_ff <= gsf_pkg::REG_RST;
      rvalid_ff <= 1'h0;
      irq_ff <= 1'h0;
    end else begin
      triggered_ff <= nxt_triggered; // R11 R12
      rdata_ff <= reg_rd_in ? rd_byte : rdata_ff;
      rvalid_ff <= reg_rd_in;
      irq_ff <= nxt_irq;
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_bypass_holds_empty: assert property ( // R07 R17
    flush |=> (fifo_count == '0) && empty
  ) else $error("buffer not empty while in bypass");

  a_fifo_full_stops: assert property ( // R08
    (beh == gsf_pkg::BEH_FIFO) && full && !fifo_pop && sample_new
    |=> full && $stable(fifo_head)
  ) else $error("full buffer in fifo mode took a sample");

  a_stream_drops_oldest: assert property ( // R10
    (beh == gsf_pkg::BEH_STREAM) && full && !read_pop && sample_new && !reg_wr_in
    |=> full && (fifo_head != $past(fifo_head) || $past(fifo_head) == latest_ff)
  ) else $error("stream mode did not drop the oldest set");

  a_status_flags: assert property ( // R04 R16
    (status_byte[gsf_pkg::STAT_FULL_BIT] == (fifo_count == CNT_W'(DEPTH))) &&
    (status_byte[gsf_pkg::STAT_EMPTY_BIT] == (fifo_count == '0))
  ) else $error("status flags disagree with stored count");

  a_watermark_pin: assert property ( // R06 R03
    irq_cfg_ff[gsf_pkg::IRQ_WTM_BIT] && (fifo_count >= CNT_W'(wtm_level))
    |=> data_ready_irq_pin_out
  ) else $error("watermark reached but pin low");

  a_pin_disabled: assert property ( // R03
    (irq_cfg_ff == gsf_pkg::REG_RST) ##1 (irq_cfg_ff == gsf_pkg::REG_RST)
    |-> !data_ready_irq_pin_out
  ) else $error("pin high with every source disabled");

  a_burst_wraps: assert property ( // R15
    reg_rd_in && (eff_addr == gsf_pkg::ADDR_AX3_HI)
    |=> addr_ptr_ff == gsf_pkg::ADDR_AX1_LO
  ) else $error("burst pointer did not wrap to the first output byte");

  a_set_read_pops: assert property ( // R14
    read_pop && !sample_new |=> fifo_count == $past(fifo_count) - CNT_W'(1)
  ) else $error("reading a whole set did not release it");

  a_trigger_to_stream: assert property ( // R11
    (mode_code == gsf_pkg::MODE_BYPASS_TO_STREAM) && trigger_event_in && !reg_wr_in
    |=> beh == gsf_pkg::BEH_STREAM
  ) else $error("trigger did not start stream behaviour");

  a_trigger_to_fifo: assert property ( // R12
    (mode_code == gsf_pkg::MODE_STREAM_TO_FIFO) && trigger_event_in && !reg_wr_in
    |=> beh == gsf_pkg::BEH_FIFO
  ) else $error("trigger did not start fifo behaviour");

  a_read_answer: assert property ( // R13
    reg_rd_in && buffered && !empty && (eff_addr == gsf_pkg::ADDR_AX1_LO)
    |=> reg_rvalid_out && (reg_rdata_out == $past(fifo_head[BW-1:0]))
  ) else $error("buffered read did not return the oldest set");

  // Pin, register and sample-slot checks on what the block itself drives.
  a_empty_pin: assert property ( // R03 R16
    irq_cfg_ff[gsf_pkg::IRQ_EMPTY_BIT] && empty |=> data_ready_irq_pin_out
  ) else $error("buffer empty and enabled but pin low");

  a_full_pin: assert property ( // R03 R16
    irq_cfg_ff[gsf_pkg::IRQ_FULL_BIT] && full |=> data_ready_irq_pin_out
  ) else $error("buffer full and enabled but pin low");

  a_read_valid: assert property ( // R13 R14
    reg_rvalid_out == $past(reg_rd_in)
  ) else $error("read valid does not follow the read strobe");

  a_fifo_refuses: assert property ( // R08
    (beh == gsf_pkg::BEH_FIFO) && full && !fifo_pop |-> !sample_ready_out
  ) else $error("full buffer in fifo mode offers to take a sample");

  a_stream_ready: assert property ( // R10
    (beh == gsf_pkg::BEH_STREAM) |-> sample_ready_out
  ) else $error("stream mode refuses a sample");

  a_latest_slot: assert property ( // R07
    sample_new |=> latest_ff == $past(sample_set)
  ) else $error("newest sample set not kept in the bypass slot");

  a_ctrl_write_lands: assert property ( // R02 R05
    reg_wr_in && (eff_addr == gsf_pkg::ADDR_BUF_CTRL) |=> ctrl_ff == $past(reg_wdata_in)
  ) else $error("buffer_control write did not land");

  a_write_clears_trigger: assert property ( // R11 R12
    reg_wr_in && (eff_addr == gsf_pkg::ADDR_BUF_CTRL) && !(trig_mode && trigger_event_in)
    |=> !triggered_ff
  ) else $error("buffer_control write did not clear the trigger");
endmodule

//--- gsf_host_model.sv
`timescale 1ns/10ps
// Host on the far side: one register byte per strobe, idle lines scrambled.
module gsf_host_model (
  input wire logic clk_in, // Block clock.
  input wire logic [7:0] rdata_in, // Read data.
  input wire logic rvalid_in, // Read data valid.
  output logic [6:0] addr_out, // Register index.
  output logic inc_out, // Burst pointer select.
  output logic wr_out, // Write strobe.
  output logic [7:0] wdata_out, // Write data.
  output logic rd_out // Read strobe.
);
  // Known levels at time zero, no strobe pending.
  initial begin
    addr_out = 7'h00;
    inc_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
  end
  // A write is taken at the edge after the strobe is raised.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    inc_out <= 1'b0;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // A read takes its byte at the edge where valid is seen high.
  task automatic rd(input logic [6:0] a, input logic inc, output logic [7:0] d);
    int n;
    @(posedge clk_in);
    addr_out <= a;
    inc_out <= inc;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    inc_out <= 1'b0;
    n = 0;
    d = 8'h00;
    // Bounded wait, so a silent design cannot hang the host.
    while (n < 4) begin
      @(posedge clk_in);
      n++;
      if (rvalid_in === 1'b1) begin
        d = rdata_in;
        n = 9;
      end
    end
  endtask
endmodule

//--- test_gyro_sample_fifo.sv
`timescale 1ns/10ps
// Self-checking bench for the sample buffer, host model on the register side.
module test_gyro_sample_fifo;
  logic clk = 1'b0; // Block clock.
  logic resetn = 1'b0; // Reset, active low.
  logic sclk = 1'b0; // Sample strobe from the other domain.
  logic [15:0] a1 = 16'h0000; // Yaw sample.
  logic [15:0] a2 = 16'h0000; // Pitch sample.
  logic [15:0] a3 = 16'h0000; // Roll sample.
  logic trig = 1'b0; // Trigger event.
  logic [6:0] addr; // Host index.
  logic inc, wr, rd, rvalid, srdy, irq; // Host strobes and flags.
  logic [7:0] wdata, rdata, cfg; // Data bytes.
  int err_total = 0; // Mismatches.
  int total_checks = 0; // Comparisons.
  int cyc = 0; // Cycles since start.
  always #4 clk = ~clk;
  gsf_host_model host (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
    .inc_out(inc), .wr_out(wr), .wdata_out(wdata), .rd_out(rd));
  gsf_gyro_sample_fifo dut (.clk_in(clk), .resetn_in(resetn), .sample_clk_in(sclk),
    .axis1_sample_in(a1), .axis2_sample_in(a2), .axis3_sample_in(a3),
    .trigger_event_in(trig), .reg_addr_in(addr), .reg_inc_in(inc), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .trigger_event_config_out(cfg), .sample_ready_out(srdy), .data_ready_irq_pin_out(irq));
  // Final verdict; also reached when the cycle ceiling runs out.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Roughly two and a half times the expected run, so only a hang reaches it.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, 1'b0, d);
    chk(d, exp);
  endtask
  // One sample set k; data held well past capture, then scrambled.
  task automatic push(input logic [7:0] k);
    @(posedge clk);
    a1 <= {8'h10, k};
    a2 <= {8'h20, k};
    a3 <= {8'h30, k};
    sclk <= 1'b1;
    repeat (10) @(posedge clk);
    sclk <= 1'b0;
    a1 <= ~a1;
    a2 <= ~a2;
    a3 <= ~a3;
    repeat (10) @(posedge clk);
  endtask
  // Burst of one set: first byte direct, the rest through the pointer.
  task automatic burst(input logic [7:0] k);
    logic [7:0] d;
    logic [7:0] exp [6];
    exp = '{k, 8'h10, k, 8'h20, k, 8'h30};
    for (int i = 0; i < 6; i++) begin
      host.rd(7'h28, i != 0, d);
      chk(d, exp[i]);
    end
  endtask
  task automatic pulse_trig();
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask
  // Register defaults, refused writes and the unmapped index.
  task automatic t_regs();
    rdc(7'h2F, 8'hA0);
    rdc(7'h2E, 8'h00);
    rdc(7'h22, 8'h00);
    rdc(7'h10, 8'h00);
    host.wr(7'h2F, 8'hFF);
    rdc(7'h2F, 8'hA0);
    host.wr(7'h30, 8'h5A);
    @(posedge clk);
    chk(cfg, 8'h5A);
    $display("regs done");
  endtask
  // Bypass keeps only the newest set and stays empty.
  task automatic t_bypass();
    push(8'h05);
    push(8'h06);
    rdc(7'h2F, 8'hA0);
    rdc(7'h28, 8'h06);
    rdc(7'h2D, 8'h30);
    chk(srdy, 1'b0);
    $display("bypass done");
  endtask
  // Fifo fill to the watermark and to full; overflow refused, oldest first.
  task automatic t_fifo();
    host.wr(7'h22, 8'h04);
    host.wr(7'h2E, 8'h24);
    for (int k = 0; k < 3; k++) push(8'(k));
    chk(irq, 1'b0);
    push(8'h03);
    chk(irq, 1'b1);
    chk(srdy, 1'b1);
    rdc(7'h2F, 8'h84);
    for (int k = 4; k < 32; k++) push(8'(k));
    rdc(7'h2F, 8'hC0);
    chk(srdy, 1'b0);
    push(8'h40);
    burst(8'h00);
    rdc(7'h2F, 8'h9F);
    host.wr(7'h22, 8'h02);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("fifo done");
  endtask
  // Restart through bypass, then stream drops the oldest set.
  task automatic t_stream();
    host.wr(7'h2E, 8'h00);
    rdc(7'h2F, 8'hA0);
    host.wr(7'h22, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    host.wr(7'h22, 8'h02);
    host.wr(7'h2E, 8'h40);
    for (int k = 0; k < 33; k++) push(8'(k));
    rdc(7'h2F, 8'hC0);
    chk(irq, 1'b1);
    chk(srdy, 1'b1);
    burst(8'h01);
    burst(8'h02);
    $display("stream done");
  endtask
  // Both trigger modes: bypass then stream, and stream-to-fifo triggered before any sample, so fifo only.
  task automatic t_trig();
    host.wr(7'h2E, 8'h00);
    host.wr(7'h2E, 8'h80);
    push(8'h50);
    rdc(7'h2F, 8'hA0);
    pulse_trig();
    push(8'h51);
    rdc(7'h2F, 8'h81);
    burst(8'h51);
    host.wr(7'h2E, 8'h00);
    host.wr(7'h2E, 8'h60);
    pulse_trig();
    for (int k = 0; k < 33; k++) push(8'(k));
    rdc(7'h2F, 8'hC0);
    burst(8'h00);
    $display("trigger done");
  endtask
  // Reset held for twelve cycles, settle the sync stages, then the tests.
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_bypass();
    t_fifo();
    t_stream();
    t_trig();
    stop_test();
  end
endmodule
